// *** ccisc_pkg.sv ***
// Purpose: constants and carriers for the clock chip interrupt/status control
// Assumes: APB slave, 32-bit data, byte address = 4 * register index
// Notes: register indices are kept as printed; byte address derived
package ccisc_pkg;
   localparam int unsigned CCISC_NSRC = 4;
   // edges after reset before the edge detector trusts its previous sample
   localparam int unsigned CCISC_WARM_EDGES = 3;
   // register indices
   localparam logic [7:0] CCISC_IDX_MASK = 8'h0E;
   localparam logic [7:0] CCISC_IDX_POL = 8'h0F;
   localparam logic [7:0] CCISC_IDX_FLAG = 8'h10;
   localparam logic [7:0] CCISC_IDX_INT_CONTROL = 8'h11;
   localparam logic [7:0] CCISC_IDX_REFST = 8'h12;
   localparam logic [7:0] CCISC_IDX_DRVCTL = 8'h13;
   localparam logic [7:0] CCISC_IDX_LIVE = 8'h14;
   // source bit positions in flag/mask/polarity/live registers
   localparam int unsigned CCISC_BIT_UNLOCK = 7;
   localparam int unsigned CCISC_BIT_LOSS = 6;
   localparam int unsigned CCISC_BIT_CAL = 5;
   localparam int unsigned CCISC_BIT_SWITCH = 1;
   localparam logic [7:0] CCISC_SRC_BITS = 8'hE2;
   // interrupt control fields
   localparam int unsigned CCISC_INT_EN = 0;
   localparam int unsigned CCISC_INT_AND = 1;
   localparam logic [7:0] CCISC_INT_CONTROL_BITS = 8'h03;
   // reference status fields
   localparam int unsigned CCISC_SEC_RISE = 7;
   localparam int unsigned CCISC_SEC_FALL = 6;
   localparam int unsigned CCISC_PRI_RISE = 5;
   localparam int unsigned CCISC_PRI_FALL = 4;
   // driver control fields; bits 3:2 are rw spare
   localparam int unsigned CCISC_A_OD = 0;
   localparam int unsigned CCISC_B_OD = 1;
   localparam int unsigned CCISC_A_LIM = 4;
   localparam int unsigned CCISC_B_LIM = 5;
   localparam logic [7:0] CCISC_DRVCTL_BITS = 8'h3F;
   localparam logic [7:0] CCISC_MASKPOL_BITS = 8'hFF;

   typedef struct packed {
      logic [7:0] mask;
      logic [7:0] pol;
      logic [7:0] int_control;
      logic [7:0] drvctl;
   } ccisc_cfg_s;

   typedef struct packed {
      logic pll_unlocked;
      logic input_signal_lost;
      logic vco_cal_busy;
      logic backup_to_main_switch;
   } ccisc_src_s;

   typedef struct packed {
      logic second_ref_rise_ok;
      logic second_ref_fall_ok;
      logic first_ref_rise_ok;
      logic first_ref_fall_ok;
   } ccisc_ref_s;

   typedef struct packed {
      logic status_out_a;
      logic status_a_oe_n;
      logic status_a_current_limit;
      logic status_out_b;
      logic status_b_oe_n;
      logic status_b_current_limit;
   } ccisc_pin_s;
endpackage : ccisc_pkg

// *** ccisc_sync.sv ***
// Purpose: two-flop synchroniser for a group of pin inputs
// Assumes: inputs asynchronous to pclk
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
module ccisc_sync #(
   parameter int unsigned W = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } ccisc_sync_s;
   ccisc_sync_s st_q, st_d;

   always_comb begin
      st_d = st_q;
      if (ce) begin
         st_d.s1 = din;
         st_d.s2 = st_q.s1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign dout = st_q.s2;
endmodule : ccisc_sync
`default_nettype wire

// *** ccisc_pindrv.sv ***
// Purpose: status pin driver control (push-pull or open drain)
// Assumes: oe_n low means the pin is driven
// Notes: open drain releases the pin instead of driving high
`timescale 1ns/1ps
`default_nettype none
module ccisc_pindrv (
   input wire logic level,
   input wire logic open_drain,
   output logic pin_o,
   output logic pin_oe_n
);
   always_comb begin
      pin_o = level;
      pin_oe_n = 1'b0;
      if (open_drain && level) begin
         pin_o = 1'b0;
         pin_oe_n = 1'b1;
      end
   end
endmodule : ccisc_pindrv
`default_nettype wire

// *** ccisc_top.sv ***
// Purpose: interrupt combine, edge flags, status pin control, APB registers
// Assumes: pclk 100 MHz, sources and reference indicators asynchronous
// Notes: nonvolatile defaults are sampled once after reset release
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module ccisc_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [9:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire ccisc_pkg::ccisc_cfg_s nv_default,
   input wire ccisc_pkg::ccisc_src_s src_in,
   input wire ccisc_pkg::ccisc_ref_s ref_in,
   input wire logic status_a_in,
   input wire logic status_b_in,
   output ccisc_pkg::ccisc_pin_s pins,
   output logic irq_level
);
   import ccisc_pkg::*;

   typedef struct packed {
      ccisc_cfg_s cfg;
      logic loaded;
      logic [CCISC_WARM_EDGES-1:0] warm;
      logic [7:0] flag;
      logic [7:0] live_prev;
      logic [31:0] rdata;
      logic irq;
   } ccisc_state_s;

   ccisc_state_s st_q, st_d;
   ccisc_src_s src_s;
   ccisc_ref_s ref_s;
   logic [7:0] live;
   logic [7:0] refst;
   logic [7:0] edge_hit;
   logic [7:0] unmasked;
   logic [7:0] wbyte;
   logic [7:0] rbyte;
   logic [7:0] idx;
   logic access;
   logic wr;
   logic rd;
   logic mapped;
   logic any_set;
   logic all_set;
   logic irq_comb;
   logic arm;

   ccisc_sync #(.W(4)) u_src_sync (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .din(src_in),
      .dout(src_s)
   );

   ccisc_sync #(.W(4)) u_ref_sync (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .din(ref_in),
      .dout(ref_s)
   );

   always_comb begin
      live = '0;
      live[CCISC_BIT_UNLOCK] = src_s.pll_unlocked;
      live[CCISC_BIT_LOSS] = src_s.input_signal_lost;
      live[CCISC_BIT_CAL] = src_s.vco_cal_busy;
      live[CCISC_BIT_SWITCH] = src_s.backup_to_main_switch;
   end

   always_comb begin
      refst = '0;
      refst[CCISC_SEC_RISE] = ref_s.second_ref_rise_ok;
      refst[CCISC_SEC_FALL] = ref_s.second_ref_fall_ok;
      refst[CCISC_PRI_RISE] = ref_s.first_ref_rise_ok;
      refst[CCISC_PRI_FALL] = ref_s.first_ref_fall_ok;
   end

   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_edge
         assign edge_hit[g] = CCISC_SRC_BITS[g] &&
            (st_q.cfg.pol[g] ? (live[g] && !st_q.live_prev[g])
                             : (!live[g] && st_q.live_prev[g]));
      end
   endgenerate

   assign unmasked = st_q.flag & ~st_q.cfg.mask & CCISC_SRC_BITS;
   assign any_set = |unmasked;
   // all unmasked sources set; with every source masked nothing fires
   assign all_set = (unmasked == (~st_q.cfg.mask & CCISC_SRC_BITS)) && any_set;

   always_comb begin
      if (st_q.cfg.int_control[CCISC_INT_AND]) begin
         irq_comb = all_set;
      end else begin
         irq_comb = any_set;
      end
      irq_comb = irq_comb && st_q.cfg.int_control[CCISC_INT_EN];
   end

   // edges only once sync and previous sample are valid
   // limitation: a source change in the first edges after reset is lost
   assign arm = st_q.cfg.int_control[CCISC_INT_EN] && st_q.warm[CCISC_WARM_EDGES-1];

   assign access = psel && penable;
   assign idx = paddr[9:2];
   assign mapped = (paddr[1:0] == 2'b00) &&
      (idx >= CCISC_IDX_MASK) && (idx <= CCISC_IDX_LIVE);
   assign wr = access && pwrite && mapped && pstrb[0];
   // latched in the setup cycle so read data stands at the access edge
   assign rd = psel && !penable && !pwrite && mapped;
   assign wbyte = pwdata[7:0];

   always_comb begin
      case (idx)
         CCISC_IDX_MASK: rbyte = st_q.cfg.mask;
         CCISC_IDX_POL: rbyte = st_q.cfg.pol;
         CCISC_IDX_FLAG: rbyte = st_q.flag & CCISC_SRC_BITS;
         CCISC_IDX_INT_CONTROL: rbyte = st_q.cfg.int_control & CCISC_INT_CONTROL_BITS;
         CCISC_IDX_REFST: rbyte = refst;
         CCISC_IDX_DRVCTL: rbyte = st_q.cfg.drvctl & CCISC_DRVCTL_BITS;
         CCISC_IDX_LIVE: rbyte = live;
         default: rbyte = '0;
      endcase
   end

   always_comb begin
      st_d = st_q;
      if (ce) begin
         st_d.live_prev = live;
         st_d.warm = {st_q.warm[CCISC_WARM_EDGES-2:0], 1'b1};
         if (!st_q.loaded) begin
            st_d.cfg.mask = nv_default.mask & CCISC_MASKPOL_BITS;
            st_d.cfg.pol = nv_default.pol & CCISC_MASKPOL_BITS;
            st_d.cfg.int_control = nv_default.int_control & CCISC_INT_CONTROL_BITS;
            st_d.cfg.drvctl = nv_default.drvctl & CCISC_DRVCTL_BITS;
            st_d.loaded = 1'b1;
         end else if (wr) begin
            case (idx)
               CCISC_IDX_MASK: st_d.cfg.mask = wbyte;
               CCISC_IDX_POL: st_d.cfg.pol = wbyte;
               CCISC_IDX_INT_CONTROL: st_d.cfg.int_control = wbyte & CCISC_INT_CONTROL_BITS;
               CCISC_IDX_DRVCTL: st_d.cfg.drvctl = wbyte & CCISC_DRVCTL_BITS;
               default: st_d.cfg = st_q.cfg;
            endcase
         end
         if (wr && (idx == CCISC_IDX_FLAG)) begin
            st_d.flag = st_q.flag & wbyte & CCISC_SRC_BITS;
         end
         // edges do not set flags when disabled, writes still clear them; set wins over clear
         if (arm) begin
            st_d.flag = st_d.flag | edge_hit;
         end
         if (rd) begin
            st_d.rdata = {24'h000000, rbyte};
         end
         st_d.irq = irq_comb;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   // single-cycle access phase; unmapped answers slverr
   assign pready = 1'b1;
   assign pslverr = access && !mapped;
   assign prdata = st_q.rdata;
   assign irq_level = st_q.irq;

   logic a_o, a_oe_n, b_o, b_oe_n;

   ccisc_pindrv u_drv_a (
      .level(st_q.irq),
      .open_drain(st_q.cfg.drvctl[CCISC_A_OD]),
      .pin_o(a_o),
      .pin_oe_n(a_oe_n)
   );

   ccisc_pindrv u_drv_b (
      .level(st_q.irq),
      .open_drain(st_q.cfg.drvctl[CCISC_B_OD]),
      .pin_o(b_o),
      .pin_oe_n(b_oe_n)
   );

   always_comb begin
      pins.status_out_a = a_o;
      pins.status_a_oe_n = a_oe_n;
      pins.status_a_current_limit = st_q.cfg.drvctl[CCISC_A_LIM];
      pins.status_out_b = b_o;
      pins.status_b_oe_n = b_oe_n;
      pins.status_b_current_limit = st_q.cfg.drvctl[CCISC_B_LIM];
   end

   // pin readback inputs unused inside; kept for board-level loopback
   logic pin_fb_unused;
   assign pin_fb_unused = status_a_in ^ status_b_in;

   AST_DISABLED_QUIET: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && !st_q.cfg.int_control[CCISC_INT_EN]) |=> !irq_level)
      else $error("interrupt raised while disabled");
   AST_FLAGS_FROZEN: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && st_q.loaded && !st_q.cfg.int_control[CCISC_INT_EN] && !wr)
      |=> $stable(st_q.flag))
      else $error("flags changed while disabled");
   AST_OR_COMBINE: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && st_q.cfg.int_control == 8'h01 && any_set) |=> irq_level)
      else $error("or combine missed");
   AST_OR_QUIET: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && !st_q.cfg.int_control[CCISC_INT_AND] && !any_set) |=> !irq_level)
      else $error("or combine fired with no flag");
   AST_AND_COMBINE: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && st_q.cfg.int_control[CCISC_INT_AND] && !all_set) |=> !irq_level)
      else $error("and combine fired early");
   AST_AND_FIRES: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && st_q.cfg.int_control[CCISC_INT_EN] && st_q.cfg.int_control[CCISC_INT_AND]
      && all_set) |=> irq_level)
      else $error("and combine missed");
   AST_ENABLE_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && st_q.loaded && wr && idx == CCISC_IDX_INT_CONTROL)
      |=> st_q.cfg.int_control[CCISC_INT_EN] == $past(wbyte[CCISC_INT_EN]))
      else $error("enable bit not written");
   AST_PINS_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
      !irq_level |-> !pins.status_out_a && !pins.status_a_oe_n
      && !pins.status_out_b && !pins.status_b_oe_n)
      else $error("status pin active without interrupt");
   AST_LIVE_READ: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && rd && idx == CCISC_IDX_LIVE) |=> prdata[7:0] == $past(live))
      else $error("live state read wrong");
   AST_SEC_REF_READ: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && rd && idx == CCISC_IDX_REFST)
      |=> prdata[CCISC_SEC_RISE] == $past(ref_s.second_ref_rise_ok)
      && prdata[CCISC_SEC_FALL] == $past(ref_s.second_ref_fall_ok))
      else $error("second reference status read wrong");
   AST_PRI_REF_READ: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && rd && idx == CCISC_IDX_REFST)
      |=> prdata[CCISC_PRI_RISE] == $past(ref_s.first_ref_rise_ok)
      && prdata[CCISC_PRI_FALL] == $past(ref_s.first_ref_fall_ok))
      else $error("first reference status read wrong");
   AST_MASK_EXCLUDES: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && (st_q.flag & ~st_q.cfg.mask & CCISC_SRC_BITS) == 8'h00) |=> !irq_level)
      else $error("masked flag raised interrupt");
   AST_EDGE_SETS: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && arm && edge_hit[CCISC_BIT_LOSS]) |=> st_q.flag[CCISC_BIT_LOSS])
      else $error("edge did not set flag");
   AST_FLAG_HOLDS: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && !(wr && idx == CCISC_IDX_FLAG) && !(arm && edge_hit != 8'h00))
      |=> $stable(st_q.flag))
      else $error("flag changed without edge or write");
   AST_WRITE_CLEARS: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && wr && idx == CCISC_IDX_FLAG && !wbyte[CCISC_BIT_CAL] && !edge_hit[CCISC_BIT_CAL])
      |=> !st_q.flag[CCISC_BIT_CAL])
      else $error("flag not cleared by write");
   AST_OD_A: assert property (@(posedge pclk) disable iff (!presetn)
      st_q.cfg.drvctl[CCISC_A_OD] |-> !(pins.status_out_a && !pins.status_a_oe_n))
      else $error("open drain a driven high");
   AST_OD_RELEASE_A: assert property (@(posedge pclk) disable iff (!presetn)
      (st_q.cfg.drvctl[CCISC_A_OD] && irq_level) |-> pins.status_a_oe_n)
      else $error("open drain a not released");
   AST_OD_B: assert property (@(posedge pclk) disable iff (!presetn)
      st_q.cfg.drvctl[CCISC_B_OD] |-> !(pins.status_out_b && !pins.status_b_oe_n))
      else $error("open drain b driven high");
   AST_OD_RELEASE_B: assert property (@(posedge pclk) disable iff (!presetn)
      (st_q.cfg.drvctl[CCISC_B_OD] && irq_level) |-> pins.status_b_oe_n)
      else $error("open drain b not released");
   AST_LIMIT_A: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && st_q.loaded && wr && idx == CCISC_IDX_DRVCTL)
      |=> pins.status_a_current_limit == $past(wbyte[CCISC_A_LIM]))
      else $error("current limit a not passed on");
   AST_LIMIT_B: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && st_q.loaded && wr && idx == CCISC_IDX_DRVCTL)
      |=> pins.status_b_current_limit == $past(wbyte[CCISC_B_LIM]))
      else $error("current limit b not passed on");
   AST_NV_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && !st_q.loaded) |=> st_q.loaded && st_q.cfg.mask == $past(nv_default.mask)
      && st_q.cfg.pol == $past(nv_default.pol))
      else $error("startup defaults not loaded");
   AST_RESERVED_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
      prdata[31:8] == 24'h000000 && (st_q.flag & ~CCISC_SRC_BITS) == 8'h00
      && (st_q.cfg.int_control & ~CCISC_INT_CONTROL_BITS) == 8'h00
      && (st_q.cfg.drvctl & ~CCISC_DRVCTL_BITS) == 8'h00)
      else $error("reserved bit set");
endmodule : ccisc_top
`default_nettype wire

// *** ccisc_host.sv ***
// Purpose: host side of the two status pins
// Assumes: board pull-ups on both pins
// Notes: a released pin reads high, never the last driven value
`timescale 1ns/1ps
`default_nettype none
module ccisc_host (
   input wire ccisc_pkg::ccisc_pin_s pins,
   output logic status_a_in,
   output logic status_b_in
);
   import ccisc_pkg::*;
   assign status_a_in = pins.status_a_oe_n ? 1'b1 : pins.status_out_a;
   assign status_b_in = pins.status_b_oe_n ? 1'b1 : pins.status_out_b;
endmodule : ccisc_host
`default_nettype wire

// *** test_clock_chip_interrupt_status_ctl.sv ***
// Purpose: random bench for interrupt combine and status pins
// Assumes: zero-wait slave, read data stands from the setup edge
// Notes: sync plus flag plus irq stages fit in eight cycles
`timescale 1ns/1ps
`default_nettype none
module test_clock_chip_interrupt_status_ctl;
   import ccisc_pkg::*;
   logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
   logic [9:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic [3:0] pstrb = 4'hF;
   logic pready, pslverr, err, irq_level, sa_in, sb_in, x;
   logic [7:0] m, p, c, d, w, ef;
   ccisc_cfg_s nv = '0;
   ccisc_src_s src = '0, ns, old;
   ccisc_ref_s rf = '0, nr;
   ccisc_pin_s pins, ep;
   int mismatches = 0, comparisons = 0;
   always #5 pclk = ~pclk;
   ccisc_top dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .nv_default(nv), .src_in(src), .ref_in(rf), .status_a_in(sa_in),
      .status_b_in(sb_in), .pins(pins), .irq_level(irq_level));
   ccisc_host host (.pins(pins), .status_a_in(sa_in), .status_b_in(sb_in));
   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", what, e, g);
      end
   endtask : chk
   task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] v);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h0, v};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      err = pslverr;
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
   function automatic logic [7:0] smap(ccisc_src_s s);
      return {s.pll_unlocked, s.input_signal_lost, s.vco_cal_busy, 3'b000,
         s.backup_to_main_switch, 1'b0};
   endfunction : smap
   function automatic logic [7:0] edges(logic [7:0] o, logic [7:0] n, logic [7:0] pl);
      return ((~o & n & pl) | (o & ~n & ~pl)) & CCISC_SRC_BITS;
   endfunction : edges
   function automatic logic exp_irq(logic [7:0] f, logic [7:0] mk, logic [7:0] ct);
      logic [7:0] u;
      logic [7:0] live;
      u = f & ~mk & CCISC_SRC_BITS;
      live = ~mk & CCISC_SRC_BITS;
      if (!ct[0]) return 1'b0;
      if (ct[1]) return (u != 8'h00) && (u == live);
      return u != 8'h00;
   endfunction : exp_irq
   function automatic ccisc_pin_s exp_pins(logic q, logic [7:0] dv);
      return {q & ~dv[0], q & dv[0], dv[4], q & ~dv[1], q & dv[1], dv[5]};
   endfunction : exp_pins
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : print_verdict
   initial begin
      repeat (20000) @(posedge pclk);
      mismatches++;
      print_verdict();
   end
   initial begin
      x = $urandom(32'hF94D);
      nv = $urandom;
      src = 4'($urandom);
      old = src;
      ef = 8'h00;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      xfer(0, CCISC_IDX_INT_CONTROL, 8'h00);
      chk("int control", {24'h0, nv.int_control & CCISC_INT_CONTROL_BITS}, rd);
      xfer(0, CCISC_IDX_DRVCTL, 8'h00);
      chk("drvctl", {24'h0, nv.drvctl & CCISC_DRVCTL_BITS}, rd);
      xfer(0, CCISC_IDX_MASK, 8'h00);
      chk("mask", {24'h0, nv.mask}, rd);
      xfer(0, CCISC_IDX_FLAG, 8'h00);
      chk("flag", 32'h0, rd);
      xfer(1, 8'h20, 8'hFF);
      chk("unmapped", 32'h1, {31'h0, err});
      $display("test reset done");
      for (int i = 0; i < 24; i++) begin
         m = (i < 4) ? 8'h00 : 8'($urandom);
         p = 8'($urandom);
         c = (i < 4) ? 8'(i) : 8'($urandom);
         d = 8'($urandom);
         w = c[0] ? 8'($urandom) : 8'hFF;
         xfer(1, CCISC_IDX_MASK, m);
         xfer(1, CCISC_IDX_POL, p);
         xfer(1, CCISC_IDX_INT_CONTROL, c);
         xfer(1, CCISC_IDX_DRVCTL, d);
         xfer(1, CCISC_IDX_FLAG, w);
         ef &= w;
         ns = 4'($urandom);
         nr = 4'($urandom);
         @(posedge pclk);
         src <= ns;
         rf <= nr;
         if (i % 6 == 5) begin
            // clock enable low: the source change must wait, irq holds
            ce <= 1'b0;
            x = exp_irq(ef, m, c);
            repeat (4) @(posedge pclk);
            chk("frozen irq", {31'h0, x}, {31'h0, irq_level});
            ce <= 1'b1;
         end
         repeat (8) @(posedge pclk);
         if (c[0]) ef |= edges(smap(old), smap(ns), p);
         old = ns;
         #1 x = exp_irq(ef, m, c);
         chk("irq", {31'h0, x}, {31'h0, irq_level});
         ep = exp_pins(x, d);
         chk("pins", {26'h0, ep}, {26'h0, pins});
         chk("host a", {31'h0, x}, {31'h0, sa_in});
         chk("host b", {31'h0, x}, {31'h0, sb_in});
         xfer(0, CCISC_IDX_LIVE, 8'h00);
         chk("live", {24'h0, smap(ns)}, rd);
         xfer(0, CCISC_IDX_FLAG, 8'h00);
         chk("flag", {24'h0, ef}, rd);
         xfer(0, CCISC_IDX_REFST, 8'h00);
         chk("refst", {24'h0, nr, 4'h0}, rd);
         xfer(0, CCISC_IDX_INT_CONTROL, 8'h00);
         chk("int control", {24'h0, c & CCISC_INT_CONTROL_BITS}, rd);
         xfer(0, CCISC_IDX_DRVCTL, 8'h00);
         chk("drvctl", {24'h0, d & CCISC_DRVCTL_BITS}, rd);
         $display("test %0d done", i);
      end
      print_verdict();
   end
endmodule : test_clock_chip_interrupt_status_ctl
`default_nettype wire
